// [core/temp_sensor_readout_regs.sv]
// register file and monitoring sequencer of the temperature monitor
//
// Behaviour
// - remote a result in bits 15:4, reset 0
// - remote b result in bits 15:4, reset 0
// - one result step is 0.125 degC
// - spi config enables at bits 5..2, 003c
// - i2c config enables at 13..10, 3cff
// - remote b monitored only while enabled
// - remote a monitored only while enabled
// - local sensor monitored only while enabled
// - resistance correction only while enabled
// - spi rate selector bits 2:0, 0007
// - i2c rate selector bits 10:8, 07ff
// - rate code halves 128x multiple per step
// - local only cycle 15 ms
// - one remote 44 or 93 ms
// - one remote plus local 59 or 108 ms
// - two remotes 88 or 186 ms
// - all sensors 103 or 201 ms
// - one ideality register per remote sensor
// - spi ideality value bits 7:0, 0000
// - i2c ideality value bits 15:8, 00ff
`timescale 1ns/10ps
module temp_sensor_readout_regs #(
   parameter int TEMP_W = 12
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        i2cMode,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic [15:0] regWrData,
   output logic      [15:0] regRdData,
   input  wire logic        convDone,
   input  wire logic [11:0] convData,
   output logic             convStart,
   output logic      [1:0]  convChannel,
   output logic             localEnable,
   output logic             remoteAEnable,
   output logic             remoteBEnable,
   output logic             correctionEnable,
   output logic      [7:0]  idealityA,
   output logic      [7:0]  idealityB,
   output logic             cycleTick
);
   if (TEMP_W != 12) begin : widthCheck
      $error("temperature width must be 12");
   end

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CH_LOCAL  = 2'b00,
      CH_A      = 2'b01,
      CH_B      = 2'b10,
      CH_NONE   = 2'b11
   } chan_type;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_CONV   = 2'b01,
      ST_WAIT   = 2'b10
   } state_type;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [3:0]  enables_r;
   logic [3:0]  enables_nxt;
   logic [2:0]  rateSel_r;
   logic [2:0]  rateSel_nxt;
   logic [7:0]  idealA_r;
   logic [7:0]  idealA_nxt;
   logic [7:0]  idealB_r;
   logic [7:0]  idealB_nxt;
   logic [15:0] rdData_r;
   logic [15:0] rdData_nxt;
   logic [15:0] resultA;
   logic [15:0] resultB;

   // layout of each field follows the selected host interface
   always_comb begin
      enables_nxt = enables_r;
      rateSel_nxt = rateSel_r;
      idealA_nxt  = idealA_r;
      idealB_nxt  = idealB_r;
      if (regWrite) begin
         case (regAddr)
            temp_sensor_pkg::SENSOR_CONFIG_OFS: begin
               if (i2cMode) begin
                  enables_nxt = regWrData[temp_sensor_pkg::CFG_LSB_I2C +: 4];
               end else begin
                  enables_nxt = regWrData[temp_sensor_pkg::CFG_LSB_SPI +: 4];
               end
            end
            temp_sensor_pkg::CONV_RATE_OFS: begin
               if (i2cMode) begin
                  rateSel_nxt = regWrData[temp_sensor_pkg::RATE_LSB_I2C +: 3];
               end else begin
                  rateSel_nxt = regWrData[temp_sensor_pkg::RATE_LSB_SPI +: 3];
               end
            end
            // high byte of spi writes is dropped
            temp_sensor_pkg::IDEALITY_A_OFS: begin
               idealA_nxt = i2cMode ? regWrData[temp_sensor_pkg::IDEAL_LSB_I2C +: 8]
                                    : regWrData[temp_sensor_pkg::IDEAL_LSB_SPI +: 8];
            end
            temp_sensor_pkg::IDEALITY_B_OFS: begin
               idealB_nxt = i2cMode ? regWrData[temp_sensor_pkg::IDEAL_LSB_I2C +: 8]
                                    : regWrData[temp_sensor_pkg::IDEAL_LSB_SPI +: 8];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rdData_nxt = 16'h0000;
      case (regAddr)
         temp_sensor_pkg::REMOTE_A_RESULT_OFS: rdData_nxt = resultA;
         temp_sensor_pkg::REMOTE_B_RESULT_OFS: rdData_nxt = resultB;
         temp_sensor_pkg::SENSOR_CONFIG_OFS: begin
            if (i2cMode) begin
               rdData_nxt = {2'b00, enables_r, 2'b00, temp_sensor_pkg::LOW_BYTE_ONES};
            end else begin
               rdData_nxt = {10'h000, enables_r, 2'b00};
            end
         end
         temp_sensor_pkg::CONV_RATE_OFS: begin
            if (i2cMode) begin
               rdData_nxt = {5'h00, rateSel_r, temp_sensor_pkg::LOW_BYTE_ONES};
            end else begin
               rdData_nxt = {13'h0000, rateSel_r};
            end
         end
         temp_sensor_pkg::IDEALITY_A_OFS: begin
            rdData_nxt = i2cMode ? {idealA_r, temp_sensor_pkg::LOW_BYTE_ONES}
                                 : {8'h00, idealA_r};
         end
         temp_sensor_pkg::IDEALITY_B_OFS: begin
            rdData_nxt = i2cMode ? {idealB_r, temp_sensor_pkg::LOW_BYTE_ONES}
                                 : {8'h00, idealB_r};
         end
         default: rdData_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         enables_r <= temp_sensor_pkg::ENABLES_RESET;
         rateSel_r <= temp_sensor_pkg::RATE_SEL_RESET;
         idealA_r  <= 8'h00;
         idealB_r  <= 8'h00;
         rdData_r  <= 16'h0000;
      end else begin
         enables_r <= enables_nxt;
         rateSel_r <= rateSel_nxt;
         idealA_r  <= idealA_nxt;
         idealB_r  <= idealB_nxt;
         rdData_r  <= rdData_nxt;
      end
   end

   // ----------------------------------------------------------------
   // monitoring sequencer
   // ----------------------------------------------------------------
   // disabled sensors are skipped; the cycle length still comes from the
   // table, so an early finish just waits out the remainder
   logic [39:0] cycleLen;
   logic [39:0] cycleCnt_r;
   logic [39:0] cycleCnt_nxt;
   state_type   state_r;
   state_type   state_nxt;
   chan_type    chan_r;
   chan_type    chan_nxt;
   logic        start_nxt;
   logic        start_r;
   logic        loadA;
   logic        loadB;

   cycle_time_lut cycleLut (
      .enables    (enables_r),
      .rateSel    (rateSel_r),
      .cycleCount (cycleLen)
   );

   function automatic chan_type nextChan(input chan_type cur, input logic [3:0] en);
      chan_type n;
      n = CH_NONE;
      if (cur == CH_NONE && en[temp_sensor_pkg::EN_LOCAL]) begin
         n = CH_LOCAL;
      end else if ((cur == CH_NONE || cur == CH_LOCAL) && en[temp_sensor_pkg::EN_A]) begin
         n = CH_A;
      end else if (cur != CH_B && en[temp_sensor_pkg::EN_B]) begin
         n = CH_B;
      end
      return n;
   endfunction : nextChan

   always_comb begin
      state_nxt    = state_r;
      chan_nxt     = chan_r;
      start_nxt    = 1'b0;
      cycleCnt_nxt = (cycleCnt_r == 40'h0) ? 40'h0 : cycleCnt_r - 40'h1;
      case (state_r)
         ST_IDLE: begin
            cycleCnt_nxt = cycleLen - 40'h1;
            chan_nxt     = nextChan(CH_NONE, enables_r);
            if (chan_nxt != CH_NONE) begin
               start_nxt = 1'b1;
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (convDone) begin
               chan_nxt = nextChan(chan_r, enables_r);
               if (chan_nxt == CH_NONE) begin
                  state_nxt = ST_WAIT;
               end else begin
                  start_nxt = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (cycleCnt_r == 40'h0) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r    <= ST_IDLE;
         chan_r     <= CH_NONE;
         start_r    <= 1'b0;
         cycleCnt_r <= 40'h0;
      end else begin
         state_r    <= state_nxt;
         chan_r     <= chan_nxt;
         start_r    <= start_nxt;
         cycleCnt_r <= cycleCnt_nxt;
      end
   end

   assign loadA = (state_r == ST_CONV) && convDone && (chan_r == CH_A);
   assign loadB = (state_r == ST_CONV) && convDone && (chan_r == CH_B);

   sensor_result_reg #(.DATA_W(TEMP_W)) resultRegA (
      .clock      (clock),
      .rst        (rst),
      .loadStrobe (loadA),
      .sample     (convData),
      .result     (resultA)
   );

   sensor_result_reg #(.DATA_W(TEMP_W)) resultRegB (
      .clock      (clock),
      .rst        (rst),
      .loadStrobe (loadB),
      .sample     (convData),
      .result     (resultB)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign regRdData        = rdData_r;
   assign convStart        = start_r;
   assign convChannel      = chan_r;
   assign localEnable      = enables_r[temp_sensor_pkg::EN_LOCAL];
   assign remoteAEnable    = enables_r[temp_sensor_pkg::EN_A];
   assign remoteBEnable    = enables_r[temp_sensor_pkg::EN_B];
   assign correctionEnable = enables_r[temp_sensor_pkg::EN_CORR];
   assign idealityA        = idealA_r;
   assign idealityB        = idealB_r;
   assign cycleTick        = (state_r == ST_WAIT) && (cycleCnt_r == 40'h0);
endmodule : temp_sensor_readout_regs

// [core/temp_sensor_pkg.sv]
// constants for the temperature sensor register block
package temp_sensor_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  REMOTE_A_RESULT_OFS = 8'h01;
   localparam logic [7:0]  REMOTE_B_RESULT_OFS = 8'h02;
   localparam logic [7:0]  SENSOR_CONFIG_OFS   = 8'h0a;
   localparam logic [7:0]  CONV_RATE_OFS       = 8'h0b;
   localparam logic [7:0]  IDEALITY_A_OFS      = 8'h21;
   localparam logic [7:0]  IDEALITY_B_OFS      = 8'h22;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RESULT_RESET        = 16'h0000;
   localparam logic [15:0] CONFIG_RESET_SPI    = 16'h003c;
   localparam logic [15:0] CONFIG_RESET_I2C    = 16'h3cff;
   localparam logic [15:0] RATE_RESET_SPI      = 16'h0007;
   localparam logic [15:0] RATE_RESET_I2C      = 16'h07ff;
   localparam logic [15:0] IDEAL_RESET_SPI     = 16'h0000;
   localparam logic [15:0] IDEAL_RESET_I2C     = 16'h00ff;
   localparam logic [3:0]  ENABLES_RESET       = 4'hf;
   localparam logic [2:0]  RATE_SEL_RESET      = 3'h7;
   localparam logic [7:0]  LOW_BYTE_ONES       = 8'hff;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          RESULT_LSB          = 4;
   localparam int          CFG_LSB_SPI         = 2;
   localparam int          CFG_LSB_I2C         = 10;
   localparam int          RATE_LSB_SPI        = 0;
   localparam int          RATE_LSB_I2C        = 8;
   localparam int          IDEAL_LSB_SPI       = 0;
   localparam int          IDEAL_LSB_I2C       = 8;
   // enable vector order {b, a, local, correction}
   localparam int          EN_B                = 3;
   localparam int          EN_A                = 2;
   localparam int          EN_LOCAL            = 1;
   localparam int          EN_CORR             = 0;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam longint      CLOCK_HZ            = 125000000;
   localparam longint      CYC_PER_MS          = CLOCK_HZ / 1000;
   localparam longint      LOCAL_ONLY_MS       = 15;
   localparam longint      ONE_REMOTE_MS       = 44;
   localparam longint      ONE_REMOTE_RC_MS    = 93;
   localparam longint      ONE_LOCAL_MS        = 59;
   localparam longint      ONE_LOCAL_RC_MS     = 108;
   localparam longint      TWO_REMOTE_MS       = 88;
   localparam longint      TWO_REMOTE_RC_MS    = 186;
   localparam longint      ALL_MS              = 103;
   localparam longint      ALL_RC_MS           = 201;
   localparam int          RATE_MULT_MAX_LOG2  = 7;
endpackage : temp_sensor_pkg

// [core/sensor_result_reg.sv]
// one remote sensor result register
`timescale 1ns/10ps
module sensor_result_reg #(
   parameter int DATA_W = 12
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              loadStrobe,
   input  wire logic [DATA_W-1:0] sample,
   output logic      [15:0]       result
);
   if (DATA_W != 12) begin : widthCheck
      $error("result width must be 12");
   end

   logic [15:0] result_r;
   logic [15:0] result_nxt;

   // only a finished conversion moves the value
   always_comb begin
      result_nxt = result_r;
      if (loadStrobe) begin
         result_nxt = {sample, 4'h0};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         result_r <= temp_sensor_pkg::RESULT_RESET;
      end else begin
         result_r <= result_nxt;
      end
   end

   assign result = result_r;
endmodule : sensor_result_reg

// [core/cycle_time_lut.sv]
// monitoring cycle length from active sensors and rate selector
`timescale 1ns/10ps
module cycle_time_lut (
   input  wire logic [3:0]  enables,
   input  wire logic [2:0]  rateSel,
   output logic      [39:0] cycleCount
);
   logic [39:0] baseMs;
   logic [1:0]  remotes;
   logic        loc;
   logic        corr;

   always_comb begin
      remotes = 2'(enables[temp_sensor_pkg::EN_A]) + 2'(enables[temp_sensor_pkg::EN_B]);
      loc     = enables[temp_sensor_pkg::EN_LOCAL];
      corr    = enables[temp_sensor_pkg::EN_CORR];
      baseMs  = 40'(temp_sensor_pkg::LOCAL_ONLY_MS);
      case ({remotes, loc})
         3'h2:    baseMs = corr ? 40'(temp_sensor_pkg::ONE_REMOTE_RC_MS)
                                : 40'(temp_sensor_pkg::ONE_REMOTE_MS);
         3'h3:    baseMs = corr ? 40'(temp_sensor_pkg::ONE_LOCAL_RC_MS)
                                : 40'(temp_sensor_pkg::ONE_LOCAL_MS);
         3'h4:    baseMs = corr ? 40'(temp_sensor_pkg::TWO_REMOTE_RC_MS)
                                : 40'(temp_sensor_pkg::TWO_REMOTE_MS);
         3'h5:    baseMs = corr ? 40'(temp_sensor_pkg::ALL_RC_MS)
                                : 40'(temp_sensor_pkg::ALL_MS);
         default: baseMs = 40'(temp_sensor_pkg::LOCAL_ONLY_MS);
      endcase
      // code 0 is 128x, each step halves the multiple
      cycleCount = (baseMs * 40'(temp_sensor_pkg::CYC_PER_MS))
                   << (3'(temp_sensor_pkg::RATE_MULT_MAX_LOG2) - rateSel);
   end
endmodule : cycle_time_lut

// [verification/temp_sensor_readout_monitor.sv]
// concurrent checks on the temperature register block ports
`timescale 1ns/10ps
module temp_sensor_readout_monitor #(
   parameter int TEMP_W = 12
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        i2cMode,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrite,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   input wire logic        convDone,
   input wire logic [11:0] convData,
   input wire logic        convStart,
   input wire logic [1:0]  convChannel,
   input wire logic        localEnable,
   input wire logic        remoteAEnable,
   input wire logic        remoteBEnable,
   input wire logic        correctionEnable,
   input wire logic [7:0]  idealityA,
   input wire logic [7:0]  idealityB,
   input wire logic        cycleTick
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_cfg_wr;
      regWrite && regAddr == temp_sensor_pkg::SENSOR_CONFIG_OFS;
   endsequence
   sequence s_local_done;
      convDone && convChannel == 2'h0 && remoteAEnable;
   endsequence
   a_cfg_spi_wr: assert property (s_cfg_wr ##0 !i2cMode |=>
      {remoteBEnable, remoteAEnable, localEnable, correctionEnable} == $past(regWrData[5:2]))
      else $error("enables differ from spi config write");
   a_cfg_i2c_wr: assert property (s_cfg_wr ##0 i2cMode |=>
      {remoteBEnable, remoteAEnable, localEnable, correctionEnable} == $past(regWrData[13:10]))
      else $error("enables differ from i2c config write");
   a_ideal_spi_wr: assert property (regWrite && !i2cMode &&
      regAddr == temp_sensor_pkg::IDEALITY_A_OFS |=> idealityA == $past(regWrData[7:0]))
      else $error("ideality a differs from spi write");
   a_ideal_i2c_wr: assert property (regWrite && i2cMode &&
      regAddr == temp_sensor_pkg::IDEALITY_B_OFS |=> idealityB == $past(regWrData[15:8]))
      else $error("ideality b differs from i2c write");
   a_result_low_zero: assert property ((regAddr == 8'h01 || regAddr == 8'h02) |=>
      regRdData[3:0] == 4'h0) else $error("result low nibble not zero");
   a_cfg_spi_rd: assert property (!i2cMode && !regWrite &&
      regAddr == temp_sensor_pkg::SENSOR_CONFIG_OFS |=> regRdData == {10'h000,
      $past(remoteBEnable), $past(remoteAEnable), $past(localEnable),
      $past(correctionEnable), 2'b00}) else $error("spi config read wrong");
   a_rate_i2c_rd: assert property (i2cMode &&
      regAddr == temp_sensor_pkg::CONV_RATE_OFS |=> regRdData[15:11] == 5'h00
      && regRdData[7:0] == 8'hff) else $error("i2c rate read wrong");
   a_start_enabled: assert property (convStart |->
      (convChannel == 2'h0 && $past(localEnable))
      || (convChannel == 2'h1 && $past(remoteAEnable))
      || (convChannel == 2'h2 && $past(remoteBEnable))) else $error("disabled sensor started");
   a_next_remote_a: assert property (s_local_done |=>
      convStart && convChannel == 2'h1) else $error("remote a not started after local");
endmodule : temp_sensor_readout_monitor

bind temp_sensor_readout_regs temp_sensor_readout_monitor #(.TEMP_W(TEMP_W))
   u_temp_sensor_readout_monitor (.clock(clock), .rst(rst), .i2cMode(i2cMode),
   .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
   .convDone(convDone), .convData(convData), .convStart(convStart),
   .convChannel(convChannel), .localEnable(localEnable), .remoteAEnable(remoteAEnable),
   .remoteBEnable(remoteBEnable), .correctionEnable(correctionEnable),
   .idealityA(idealityA), .idealityB(idealityB), .cycleTick(cycleTick));

// [verification/conv_partner_model.sv]
// behavioural converter answering conversion starts
`timescale 1ns/10ps
module conv_partner_model (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        convStart,
   input  wire logic [1:0]  convChannel,
   input  wire logic [11:0] sampleL,
   input  wire logic [11:0] sampleA,
   input  wire logic [11:0] sampleB,
   input  wire logic [3:0]  latency,
   output logic             convDone,
   output logic      [11:0] convData
);
   logic       busy;
   logic [1:0] chan;
   logic [3:0] waitCnt;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         busy     <= 1'b0;
         chan     <= 2'h3;
         waitCnt  <= 4'h0;
         convDone <= 1'b0;
         convData <= 12'h000;
      end else begin
         convDone <= !convStart && busy && waitCnt == 4'h0;
         // data not valid: toggle so a stale value is never mistaken for a result
         if (convStart) begin
            busy     <= 1'b1;
            chan     <= convChannel;
            waitCnt  <= latency;
            convData <= ~convData;
         end else if (busy && waitCnt == 4'h0) begin
            busy     <= 1'b0;
            // two's complement count of 0.125 degC steps
            convData <= chan == 2'h1 ? sampleA : chan == 2'h2 ? sampleB : sampleL;
         end else begin
            if (busy) begin
               waitCnt <= waitCnt - 4'h1;
            end
            convData <= ~convData;
         end
      end
   end
endmodule : conv_partner_model

// [verification/temp_sensor_readout_regs_tb.sv]
// self-checking bench of the temperature register block
`timescale 1ns/10ps
module temp_sensor_readout_regs_tb;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        i2cMode = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic        regWrite = 1'b0;
   logic [15:0] regWrData = 16'h0000;
   logic [15:0] regRdData;
   logic        convDone;
   logic [11:0] convData;
   logic        convStart;
   logic [1:0]  convChannel;
   logic        localEnable, remoteAEnable, remoteBEnable, correctionEnable;
   logic [7:0]  idealityA, idealityB;
   logic        cycleTick;
   logic [11:0] sampleL = 12'h000, sampleA = 12'h000, sampleB = 12'h000;
   logic [3:0]  latency = 4'h0;
   logic [31:0] seed = 32'hc736;
   int          failures = 0;
   int          comparisons = 0;
   int          doneCount = 0;
   int          tickCount = 0;
   always #4 clock = ~clock;
   // counted from reset release, so conversions finished during the reset reads still count
   always @(posedge clock) begin
      if (rst) begin
         doneCount <= 0;
         tickCount <= 0;
      end else begin
         doneCount <= doneCount + int'(convDone === 1'b1);
         tickCount <= tickCount + int'(cycleTick === 1'b1);
      end
   end
   temp_sensor_readout_regs u_temp_sensor_readout_regs (.clock(clock), .rst(rst),
      .i2cMode(i2cMode), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
      .regRdData(regRdData), .convDone(convDone), .convData(convData),
      .convStart(convStart), .convChannel(convChannel), .localEnable(localEnable),
      .remoteAEnable(remoteAEnable), .remoteBEnable(remoteBEnable),
      .correctionEnable(correctionEnable), .idealityA(idealityA), .idealityB(idealityB),
      .cycleTick(cycleTick));
   conv_partner_model u_conv_partner_model (.clock(clock), .rst(rst), .convStart(convStart),
      .convChannel(convChannel), .sampleL(sampleL), .sampleA(sampleA), .sampleB(sampleB),
      .latency(latency), .convDone(convDone), .convData(convData));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction : lfsr
   function automatic logic [15:0] expect_reg(input logic m, input logic [7:0] a,
                                              input logic [15:0] d);
      case (a)
         temp_sensor_pkg::SENSOR_CONFIG_OFS: return m ? {2'b00, d[13:10], 2'b00, 8'hff}
                                                      : {10'h000, d[5:2], 2'b00};
         temp_sensor_pkg::CONV_RATE_OFS: return m ? {5'h00, d[10:8], 8'hff} : {13'h0000, d[2:0]};
         temp_sensor_pkg::IDEALITY_A_OFS,
         temp_sensor_pkg::IDEALITY_B_OFS: return m ? {d[15:8], 8'hff} : {8'h00, d[7:0]};
         default: return 16'h0000;
      endcase
   endfunction : expect_reg
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr   <= a;
      regWrite  <= 1'b1;
      regWrData <= d;
      @(posedge clock);
      regWrite  <= 1'b0;
   endtask : wr
   task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock);
      regAddr <= a;
      @(posedge clock);
      @(negedge clock);
      check(name, regRdData, exp);
   endtask : rdchk
   task automatic start(input logic m, input logic slow);
      rst     <= 1'b1;
      i2cMode <= m;
      seed = lfsr(seed);
      sampleL <= seed[11:0];
      sampleA <= seed[23:12];
      latency <= slow ? 4'hf : seed[27:24];
      seed = lfsr(seed);
      sampleB <= seed[11:0];
      repeat (8) @(posedge clock);
      rst <= 1'b0;
   endtask : start
   // window far shorter than one monitoring cycle, so no cycle may end inside it
   task automatic wait_done(input int n);
      repeat (3000) @(posedge clock);
      check("conversion count", 16'(doneCount), 16'(n));
      check("early cycle end", 16'(tickCount), 16'h0000);
   endtask : wait_done
   task automatic run_regs;
      logic [7:0]  ad;
      logic [7:0]  addrs [5];
      addrs = '{8'h0a, 8'h0b, 8'h21, 8'h22, 8'h03};
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         ad = addrs[seed[2:0] % 5];
         wr(ad, seed[31:16]);
         rdchk("register readback", ad, expect_reg(i2cMode, ad, seed[31:16]));
      end
   endtask : run_regs
   task automatic report_and_stop;
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      start(1'b0, 1'b0);
      rdchk("result a reset", 8'h01, 16'h0000);
      rdchk("result b reset", 8'h02, 16'h0000);
      rdchk("config reset", 8'h0a, 16'h003c);
      rdchk("rate reset", 8'h0b, 16'h0007);
      rdchk("ideality a reset", 8'h21, 16'h0000);
      rdchk("ideality b reset", 8'h22, 16'h0000);
      wait_done(3);
      rdchk("result a", 8'h01, {sampleA, 4'h0});
      rdchk("result b", 8'h02, {sampleB, 4'h0});
      wr(8'h01, 16'hffff);
      rdchk("result a read only", 8'h01, {sampleA, 4'h0});
      run_regs();
      start(1'b1, 1'b1);
      rdchk("i2c result a reset", 8'h01, 16'h0000);
      rdchk("i2c rate reset", 8'h0b, 16'h07ff);
      rdchk("i2c ideality a reset", 8'h21, 16'h00ff);
      rdchk("i2c ideality b reset", 8'h22, 16'h00ff);
      rdchk("i2c config reset", 8'h0a, 16'h3cff);
      // remote a off before local finishes, so the sequencer must skip it
      wr(8'h0a, {seed[31:30], 4'b1011, seed[9:0]});
      wait_done(2);
      rdchk("skipped result a", 8'h01, 16'h0000);
      rdchk("i2c result b", 8'h02, {sampleB, 4'h0});
      run_regs();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      report_and_stop();
   end
endmodule : temp_sensor_readout_regs_tb
